// *** rtl/pwmcps_top.sv ***
// timer clock prescale configuration: apb register, shadows, prescaler
// assumes apb master in the i_clk domain and an external timer counter
//
// The APB slave port was left to the implementer.
module pwmcps_top (
    input  wire logic                I_CLK,              // 20 mhz clock
    input  wire logic                I_SRST,             // sync reset
    input  wire logic                I_CE,               // clock enable
    input  wire logic                I_PSEL,             // apb select
    input  wire logic                I_PENABLE,          // apb enable
    input  wire logic                I_PWRITE,           // apb write
    input  wire logic [7:0]          I_PADDR,            // apb address
    input  wire logic [31:0]         I_PWDATA,           // apb wdata
    input  wire logic [3:0]          I_PSTRB,            // apb strobes
    output logic [31:0]              O_PRDATA,           // apb rdata
    output logic                     O_PREADY,           // apb ready
    output logic                     O_PSLVERR,          // apb error
    input  wire logic                I_PWM_STARTED,      // pwm running
    input  wire logic                I_CAPTURE_MODE,     // capture mode
    input  wire logic                I_TIMER_CLOCK_TICK, // timer clock
    input  wire logic [11:0]         I_TIMER_COUNT,      // counter value
    input  wire logic [11:0]         I_RELOAD_VALUE,     // reload value
    output pwmcps_pkg::pwmcps_cfg_s  O_ACTIVE_CFG,       // applied config
    output logic                     O_PLL_ENABLE,       // pll on
    output logic [6:0]               O_TIMER_CLOCK_MHZ,  // timer clock
    output logic [3:0]               O_INSTR_CLOCK_MHZ,  // instr clock
    output logic                     O_COUNT_ENABLE,     // increment
    output logic                     O_RUN_MODE,         // run mode
    output logic                     O_OVERFLOW          // wrapped
);
    import pwmcps_pkg::*;

    // ************************************************************
    // declarations
    // ************************************************************
    pwmcps_cfg_s written_reg;   // value software last wrote
    logic [1:0]  div_act_reg;   // applied pll divide select
    logic [2:0]  ps_act_reg;    // applied prescale select
    logic [31:0] rdata_reg;     // read data captured in setup
    logic        rvalid_reg;    // rdata_reg belongs to this transfer
    logic        hit;           // address decodes to the register
    logic        access;        // apb access phase completing
    logic        wr_en;         // accepted write to lane 0
    pwmcps_cfg_s wdata;         // write data as config fields
    pwmcps_cfg_s written_next;  // next value of written_reg
    logic        run;           // timer run mode
    logic        entry;         // run mode just entered
    logic        overflow;      // counter overflow pulse
    logic        count_en;      // prescaler output
    logic        pll_next;      // pll enable after this write

    assign hit    = (I_PADDR == PWMCPS_ADDR_CFG);
    assign access = I_PSEL && I_PENABLE && rvalid_reg && I_CE;
    assign wr_en  = access && I_PWRITE && hit && I_PSTRB[0];
    assign wdata  = pwmcps_cfg_s'(I_PWDATA[7:0]);

    // ************************************************************
    // apb handshake
    // ************************************************************
    // zero wait states: data is caught in setup, ready rises in access
    assign O_PREADY  = access;
    assign O_PSLVERR = access && !hit; // unmapped address answers error

    // read data register; refreshed every selected cycle before the access completes, so a frozen
    // setup cycle can never hand back stale data
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            rdata_reg  <= 32'h0;
            rvalid_reg <= 1'b0;
        end else if (I_CE) begin
            rvalid_reg <= I_PSEL && !access;
            if (I_PSEL && !access) begin
                // reads show the written value, not the applied one
                rdata_reg <= hit ? {24'h0, written_reg} : 32'h0;
            end
        end
    end

    assign O_PRDATA = rdata_reg;

    // ************************************************************
    // write filtering
    // ************************************************************
    // pll enable and timer select have write guards and keep their value when refused; no pll forces instruction select to zero
    always_comb begin
        written_next = written_reg;
        pll_next     = written_reg.pll_enable;
        if (wr_en) begin
            if (!run) begin
                pll_next = wdata.pll_enable;
            end
            written_next.pll_enable        = pll_next;
            written_next.pll_divide_select = wdata.pll_divide_select;
            written_next.timer_prescale_select =
                wdata.timer_prescale_select;
            // timer source frozen in run, and needs the pll to set
            if (!run && (pll_next || !wdata.timer_clock_select)) begin
                written_next.timer_clock_select =
                    wdata.timer_clock_select;
            end
            // instruction source may switch on the fly
            written_next.instruction_clock_select =
                wdata.instruction_clock_select;
        end
        // no pll means no fast instruction clock, whatever was written
        if (!written_next.pll_enable) begin
            written_next.instruction_clock_select = 1'b0;
        end
    end

    // ************************************************************
    // written configuration register
    // ************************************************************
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            written_reg <= pwmcps_cfg_s'(PWMCPS_CFG_RESET);
        end else if (I_CE) begin
            written_reg <= written_next;
        end
    end

    // ************************************************************
    // shadow of the deferred fields
    // ************************************************************
    // loading from the written value costs one cycle of lag when idle,
    // but keeps the applied divide constant for a whole pwm cycle
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            div_act_reg <= 2'h0;
            ps_act_reg  <= 3'h0;
        end else if (I_CE) begin
            if (overflow || !run) begin
                div_act_reg <= written_reg.pll_divide_select;
                ps_act_reg  <= written_reg.timer_prescale_select;
            end
        end
    end

    // ************************************************************
    // applied configuration and derived frequencies
    // ************************************************************
    always_comb begin
        O_ACTIVE_CFG                       = written_reg;
        O_ACTIVE_CFG.pll_divide_select     = div_act_reg;
        O_ACTIVE_CFG.timer_prescale_select = ps_act_reg;
    end

    assign O_PLL_ENABLE      = written_reg.pll_enable;
    assign O_TIMER_CLOCK_MHZ = pwmcps_tclk_mhz(O_ACTIVE_CFG);
    assign O_INSTR_CLOCK_MHZ = written_reg.instruction_clock_select
                               ? PWMCPS_ICLK_FAST_MHZ
                               : PWMCPS_ICLK_SLOW_MHZ;
    assign O_COUNT_ENABLE    = count_en;
    assign O_RUN_MODE        = run;
    assign O_OVERFLOW        = overflow;

    // ************************************************************
    // submodules
    // ************************************************************
    // run detection sees the enable it caused, so overflow trails the
    // wrapping increment by one cycle
    pwmcps_run_detect u_run (
        .i_clk       (I_CLK),
        .i_srst      (I_SRST),
        .i_ce        (I_CE),
        .i_pwm_start (I_PWM_STARTED),
        .i_capture   (I_CAPTURE_MODE),
        .i_count_en  (count_en),
        .i_count     (I_TIMER_COUNT),
        .i_reload    (I_RELOAD_VALUE),
        .o_run       (run),
        .o_entry     (entry),
        .o_overflow  (overflow)
    );

    pwmcps_prescaler u_ps (
        .i_clk      (I_CLK),
        .i_srst     (I_SRST),
        .i_ce       (I_CE),
        .i_run      (run),
        .i_restart  (entry),
        .i_tick     (I_TIMER_CLOCK_TICK),
        .i_ps       (ps_act_reg),
        .o_ce_pulse (count_en)
    );

    // ************************************************************
    // assertions
    // ************************************************************
    property p_reset_clears;
        @(posedge I_CLK)
        I_SRST |=> (written_reg == pwmcps_cfg_s'(PWMCPS_CFG_RESET)
                    && div_act_reg == 2'h0 && ps_act_reg == 3'h0);
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("configuration not cleared by reset");

    property p_pll_write;
        @(posedge I_CLK) disable iff (I_SRST)
        (wr_en && !run) |=> (O_PLL_ENABLE == $past(I_PWDATA[7]));
    endproperty
    a_pll_write: assert property (p_pll_write)
        else $error("pll enable write not taken");

    property p_pll_frozen;
        @(posedge I_CLK) disable iff (I_SRST)
        (wr_en && run) |=> $stable(O_PLL_ENABLE);
    endproperty
    a_pll_frozen: assert property (p_pll_frozen)
        else $error("pll enable changed during run mode");

    property p_div_deferred;
        @(posedge I_CLK) disable iff (I_SRST)
        (I_CE && run && !overflow) |=> $stable(div_act_reg);
    endproperty
    a_div_deferred: assert property (p_div_deferred)
        else $error("divide select applied before overflow");

    property p_tsel_needs_pll;
        @(posedge I_CLK) disable iff (I_SRST)
        (wr_en && !written_reg.timer_clock_select
            && !written_next.pll_enable)
            |=> !written_reg.timer_clock_select;
    endproperty
    a_tsel_needs_pll: assert property (p_tsel_needs_pll)
        else $error("timer select set without pll");

    property p_tsel_frozen;
        @(posedge I_CLK) disable iff (I_SRST)
        (wr_en && run) |=> $stable(written_reg.timer_clock_select);
    endproperty
    a_tsel_frozen: assert property (p_tsel_frozen)
        else $error("timer select changed during run mode");

    property p_isel_forced;
        @(posedge I_CLK) disable iff (I_SRST)
        !written_reg.pll_enable |-> !written_reg.instruction_clock_select
                                    && O_INSTR_CLOCK_MHZ == 4'h1;
    endproperty
    a_isel_forced: assert property (p_isel_forced)
        else $error("instruction select set without pll");

    property p_isel_on_fly;
        @(posedge I_CLK) disable iff (I_SRST)
        (wr_en && written_reg.pll_enable && run)
            |=> (written_reg.instruction_clock_select
                 == $past(I_PWDATA[3]));
    endproperty
    a_isel_on_fly: assert property (p_isel_on_fly)
        else $error("instruction select write refused");

    property p_tclk_freq;
        @(posedge I_CLK) disable iff (I_SRST)
        O_ACTIVE_CFG.timer_clock_select |->
            O_TIMER_CLOCK_MHZ == (div_act_reg == 2'h0 ? 7'h08
                                  : div_act_reg == 2'h1 ? 7'h10
                                  : div_act_reg == 2'h2 ? 7'h20 : 7'h40);
    endproperty
    a_tclk_freq: assert property (p_tclk_freq)
        else $error("timer clock frequency wrong");

    property p_read_written;
        @(posedge I_CLK) disable iff (I_SRST)
        (access && !I_PWRITE && hit && !wr_en)
            |-> O_PRDATA[7:0] == written_reg;
    endproperty
    a_read_written: assert property (p_read_written)
        else $error("read does not return written value");

    property p_shadow_idle;
        @(posedge I_CLK) disable iff (I_SRST)
        (I_CE && !run) |=> (ps_act_reg
                            == $past(written_reg.timer_prescale_select));
    endproperty
    a_shadow_idle: assert property (p_shadow_idle)
        else $error("shadow not loaded while idle");

    property p_ps_deferred;
        @(posedge I_CLK) disable iff (I_SRST)
        (I_CE && run && !overflow) |=> $stable(ps_act_reg);
    endproperty
    a_ps_deferred: assert property (p_ps_deferred)
        else $error("prescale select applied before overflow");

    // both shadows take what software held in the wrapping cycle
    property p_shadow_overflow;
        @(posedge I_CLK) disable iff (I_SRST)
        (I_CE && overflow) |=>
            (div_act_reg == $past(written_reg.pll_divide_select)
             && ps_act_reg == $past(written_reg.timer_prescale_select));
    endproperty
    a_shadow_overflow: assert property (p_shadow_overflow)
        else $error("shadow not loaded at overflow");

    property p_iclk_fast;
        @(posedge I_CLK) disable iff (I_SRST)
        written_reg.instruction_clock_select |-> O_INSTR_CLOCK_MHZ == 4'h8;
    endproperty
    a_iclk_fast: assert property (p_iclk_fast)
        else $error("instruction clock not on pll output");

    // slow timer source is the instruction clock itself
    property p_tclk_slow;
        @(posedge I_CLK) disable iff (I_SRST)
        !O_ACTIVE_CFG.timer_clock_select
            |-> O_TIMER_CLOCK_MHZ == {3'h0, O_INSTR_CLOCK_MHZ};
    endproperty
    a_tclk_slow: assert property (p_tclk_slow)
        else $error("slow timer clock does not follow instruction clock");

    // a divide above one leaves a quiet cycle after every pulse
    property p_single_pulse;
        @(posedge I_CLK) disable iff (I_SRST)
        (I_CE && count_en && ps_act_reg != 3'h0) |=> !count_en;
    endproperty
    a_single_pulse: assert property (p_single_pulse)
        else $error("count enable longer than one cycle");

    c_overflow: cover property (@(posedge I_CLK) disable iff (I_SRST)
        overflow ##1 run);
    c_write_in_run: cover property (@(posedge I_CLK) disable iff (I_SRST)
        wr_en && run);
    c_div8: cover property (@(posedge I_CLK) disable iff (I_SRST)
        count_en && ps_act_reg == 3'h7);
    c_capture_run: cover property (@(posedge I_CLK) disable iff (I_SRST)
        I_CAPTURE_MODE && run);
    c_tsel_refused: cover property (@(posedge I_CLK) disable iff (I_SRST)
        wr_en && !pll_next && wdata.timer_clock_select);

endmodule : pwmcps_top

// *** common/pwmcps_pkg.sv ***
// shared constants, field layout and types of the timer clock prescale block
// assumes one 20 MHz clock and an apb master with 32-bit data
// What this block does
// - reset clears whole configuration register to zero
// - bit 7 enables the pll
// - pll enable write ignored while timer runs
// - bits 6:5 pick pll clock 8/16/32/64 mhz
// - divide select deferred to overflow; reads written
// - bit 4 picks timer clock source
// - timer clock 1/8 mhz or pll frequency
// - timer select set needs pll; frozen while running
// - bit 3 picks instruction clock source
// - pll disabled forces instruction select to zero
// - instruction select changes freely once pll on
// - bits 2:0 divide timer clock by value+1
// - prescale deferred to overflow; reads written
// - run mode: pwm started or capture mode
// - pwm counter overflows to zero after reload
package pwmcps_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] PWMCPS_ADDR_CFG  = 8'ha4; // config word
    localparam logic [7:0] PWMCPS_CFG_RESET = 8'h00; // reset value
    localparam int PWMCPS_BIT_PLL_EN = 7;            // pll enable
    localparam int PWMCPS_BIT_DIV_HI = 6;            // divide select msb
    localparam int PWMCPS_BIT_DIV_LO = 5;            // divide select lsb
    localparam int PWMCPS_BIT_TSEL   = 4;            // timer clock select
    localparam int PWMCPS_BIT_ISEL   = 3;            // instr clock select
    localparam int PWMCPS_BIT_PS_HI  = 2;            // prescale msb
    localparam int PWMCPS_BIT_PS_LO  = 0;            // prescale lsb

    // ************************************************************
    // clock figures and counter limits
    // ************************************************************
    localparam logic [6:0]  PWMCPS_PLL_BASE_MHZ  = 7'h08; // divide code 0
    localparam logic [3:0]  PWMCPS_ICLK_SLOW_MHZ = 4'h1;  // osc over two
    localparam logic [3:0]  PWMCPS_ICLK_FAST_MHZ = 4'h8;  // pll slowest
    localparam logic [11:0] PWMCPS_CAPTURE_LIMIT = 12'hfff; // capture wrap
    localparam logic [2:0]  PWMCPS_PS_ZERO       = 3'h0;  // prescale start

    // configuration word, laid out as the register bits
    typedef struct packed {
        logic       pll_enable;               // pll on
        logic [1:0] pll_divide_select;        // pll output divide
        logic       timer_clock_select;       // 1 = pll output
        logic       instruction_clock_select; // 1 = pll slowest output
        logic [2:0] timer_prescale_select;    // divide minus one
    } pwmcps_cfg_s;

    // timer clock frequency in mhz for a configuration
    function automatic logic [6:0] pwmcps_tclk_mhz(input pwmcps_cfg_s c);
        logic [6:0] f;
        f = {3'h0, PWMCPS_ICLK_SLOW_MHZ};
        if (c.timer_clock_select) begin
            f = PWMCPS_PLL_BASE_MHZ << c.pll_divide_select;
        end else if (c.instruction_clock_select) begin
            f = {3'h0, PWMCPS_ICLK_FAST_MHZ};
        end
        return f;
    endfunction : pwmcps_tclk_mhz

endpackage : pwmcps_pkg

// *** rtl/pwmcps_prescaler.sv ***
// divide-by-n prescaler turning timer clock ticks into count enables
// assumes ticks are one-cycle pulses synchronous to i_clk
module pwmcps_prescaler (
    input  wire logic       i_clk,     // system clock
    input  wire logic       i_srst,    // sync reset, high
    input  wire logic       i_ce,      // clock enable
    input  wire logic       i_run,     // timer in run mode
    input  wire logic       i_restart, // mode entered
    input  wire logic       i_tick,    // timer clock tick
    input  wire logic [2:0] i_ps,      // active prescale code
    output logic            o_ce_pulse // counter increment
);
    import pwmcps_pkg::*;

    logic [2:0] cnt_reg; // ticks seen in this period

    // ************************************************************
    // tick counter
    // ************************************************************
    // restart wins over a tick so the first period is always whole
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cnt_reg <= 3'h0;
        end else if (i_ce) begin
            if (i_restart || !i_run) begin
                cnt_reg <= PWMCPS_PS_ZERO;
            end else if (i_tick) begin
                cnt_reg <= (cnt_reg >= i_ps) ? PWMCPS_PS_ZERO
                                             : cnt_reg + 3'h1;
            end
        end
    end

    // pulse on the last tick of a period
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_ce_pulse <= 1'b0;
        end else if (i_ce) begin
            o_ce_pulse <= i_run && !i_restart && i_tick
                          && (cnt_reg >= i_ps);
        end
    end

    property p_pulse_at_end;
        @(posedge i_clk) disable iff (i_srst)
        (i_ce && i_run && !i_restart && i_tick && cnt_reg == i_ps)
            |=> o_ce_pulse;
    endproperty
    a_pulse_at_end: assert property (p_pulse_at_end)
        else $error("count enable missing at end of period");

    property p_restart_zero;
        @(posedge i_clk) disable iff (i_srst)
        (i_ce && i_restart) |=> (cnt_reg == 3'h0 && !o_ce_pulse);
    endproperty
    a_restart_zero: assert property (p_restart_zero)
        else $error("prescaler not restarted");

endmodule : pwmcps_prescaler

// *** rtl/pwmcps_run_detect.sv ***
// run mode and counter overflow detection for the timer
// assumes the external counter steps on each count enable pulse
module pwmcps_run_detect (
    input  wire logic        i_clk,       // system clock
    input  wire logic        i_srst,      // sync reset, high
    input  wire logic        i_ce,        // clock enable
    input  wire logic        i_pwm_start, // pwm counter started
    input  wire logic        i_capture,   // capture mode selected
    input  wire logic        i_count_en,  // counter increments
    input  wire logic [11:0] i_count,     // counter value
    input  wire logic [11:0] i_reload,    // reload period value
    output logic             o_run,       // run mode
    output logic             o_entry,     // run mode just entered
    output logic             o_overflow   // counter wrapped
);
    import pwmcps_pkg::*;

    logic        run_prev_reg; // run mode last cycle
    logic [11:0] limit;        // wrap point for this mode

    assign o_run = i_pwm_start || i_capture;
    assign limit = i_capture ? PWMCPS_CAPTURE_LIMIT : i_reload;

    // ************************************************************
    // entry and overflow pulses
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            run_prev_reg <= 1'b0;
            o_entry      <= 1'b0;
            o_overflow   <= 1'b0;
        end else if (i_ce) begin
            run_prev_reg <= o_run;
            o_entry      <= o_run && !run_prev_reg;
            o_overflow   <= o_run && i_count_en && (i_count == limit);
        end
    end

    property p_overflow_at_reload;
        @(posedge i_clk) disable iff (i_srst)
        (i_ce && i_pwm_start && !i_capture && i_count_en
            && i_count == i_reload) |=> o_overflow;
    endproperty
    a_overflow_at_reload: assert property (p_overflow_at_reload)
        else $error("overflow not flagged at reload value");

endmodule : pwmcps_run_detect

// *** testbench/test_pwm_timer_clock_prescale.sv ***
// self-checking bench for the timer clock prescale block
// assumes the block answers apb on its own ready and keeps i_ce high
module test_pwm_timer_clock_prescale;
    timeunit 1ns;
    timeprecision 1ns;
    import pwmcps_pkg::*;

    // ****************************************************************
    // stimulus and observation signals
    // ****************************************************************
    logic        clk, srst, psel, penable, pwrite;  // clock, reset, apb
    logic [7:0]  paddr;                              // apb address
    logic [31:0] pwdata, prdata;                     // apb data
    logic        pready, pslverr, pwm_on, capt, tick; // status lines
    logic [11:0] count, reload;                      // external counter
    pwmcps_cfg_s act;                                // applied config
    logic        pll_on, cnt_en, run, ovf;           // block outputs
    logic [6:0]  tmhz;                               // timer clock mhz
    logic [3:0]  imhz;                               // instr clock mhz
    int          n_mismatch, total_checks, gap;      // bookkeeping
    logic [31:0] rd;                                 // last read word
    logic        err;                                // last error flag
    localparam int LOCK_WAIT = 20;                   // pll lock wait, cycles

    pwmcps_top u_dut (.I_CLK(clk), .I_SRST(srst), .I_CE(1'b1),
        .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(4'h1),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_PWM_STARTED(pwm_on), .I_CAPTURE_MODE(capt),
        .I_TIMER_CLOCK_TICK(tick), .I_TIMER_COUNT(count),
        .I_RELOAD_VALUE(reload), .O_ACTIVE_CFG(act), .O_PLL_ENABLE(pll_on),
        .O_TIMER_CLOCK_MHZ(tmhz), .O_INSTR_CLOCK_MHZ(imhz),
        .O_COUNT_ENABLE(cnt_en), .O_RUN_MODE(run), .O_OVERFLOW(ovf));

    // 50 ns period, free running
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    // one compare; the expected value always comes from the bench
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; request held until ready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) chk(32'h0, 32'h1);
    endtask : apb

    // cycles between two count enables, judged at falling edges
    task automatic ce_gap();
        int n;
        n = 0;
        @(negedge clk);
        while (cnt_en !== 1'b1 && n < 50) begin @(negedge clk); n++; end
        gap = 1;
        @(negedge clk);
        while (cnt_en !== 1'b1 && gap < 50) begin @(negedge clk); gap++; end
    endtask : ce_gap

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict

    // ****************************************************************
    // scenarios
    // ****************************************************************
    // guards while idle: select bits need the pll, then a full setup
    task automatic t_idle();
        apb(1'b0, PWMCPS_ADDR_CFG, 32'h0); chk(rd, 32'h0);
        chk({25'h0, tmhz}, 32'h1);
        apb(1'b1, PWMCPS_ADDR_CFG, 32'h18);
        apb(1'b0, PWMCPS_ADDR_CFG, 32'h0); chk(rd, 32'h0);
        apb(1'b1, PWMCPS_ADDR_CFG, 32'h80);
        repeat (LOCK_WAIT) @(posedge clk);
        apb(1'b1, PWMCPS_ADDR_CFG, 32'h88);
        apb(1'b0, PWMCPS_ADDR_CFG, 32'h0); chk(rd, 32'h88);
        chk({25'h0, tmhz}, 32'h8);
        apb(1'b1, PWMCPS_ADDR_CFG, 32'hdb);
        apb(1'b0, PWMCPS_ADDR_CFG, 32'h0); chk(rd, 32'hdb);
        chk({31'h0, pll_on}, 32'h1);
        chk({25'h0, tmhz}, 32'h20);
        chk({28'h0, imhz}, 32'h8);
        apb(1'b0, 8'ha5, 32'h0); chk({rd[30:0], err}, 32'h1);
        $display("test idle done");
    endtask : t_idle

    // running: guarded bits hold, deferred fields wait for overflow
    task automatic t_run();
        tick <= 1'b1; reload <= 12'h005; count <= 12'h005; pwm_on <= 1'b1;
        ce_gap(); chk(32'(gap), 32'h4);
        chk({31'h0, run}, 32'h1);
        @(posedge clk);
        count <= 12'h000;
        apb(1'b1, PWMCPS_ADDR_CFG, 32'h00);
        apb(1'b0, PWMCPS_ADDR_CFG, 32'h0); chk(rd, 32'h90);
        chk({29'h0, act.timer_prescale_select}, 32'h3);
        chk({30'h0, act.pll_divide_select}, 32'h2);
        count <= 12'h005;
        gap = 0;
        while (ovf !== 1'b1 && gap < 50) begin @(negedge clk); gap++; end
        chk({31'h0, ovf}, 32'h1);
        repeat (2) @(negedge clk);
        chk({24'h0, act}, 32'h90);
        ce_gap(); chk(32'(gap), 32'h1);
        apb(1'b1, PWMCPS_ADDR_CFG, 32'h98);
        apb(1'b0, PWMCPS_ADDR_CFG, 32'h0); chk(rd, 32'h98);
        chk({28'h0, imhz}, 32'h8);
        pwm_on <= 1'b0; capt <= 1'b1;
        @(negedge clk); chk({31'h0, run}, 32'h1);
        @(posedge clk);
        capt <= 1'b0;
        @(negedge clk); chk({31'h0, run}, 32'h0);
        apb(1'b1, PWMCPS_ADDR_CFG, 32'h08);
        apb(1'b0, PWMCPS_ADDR_CFG, 32'h0); chk(rd, 32'h0);
        $display("test run done");
    endtask : t_run

    // main sequence: reset for four cycles, then the scenarios
    initial begin
        n_mismatch = 0; total_checks = 0; srst = 1'b1; psel = 1'b0;
        penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        pwm_on = 1'b0; capt = 1'b0; tick = 1'b0;
        count = 12'h000; reload = 12'h000;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        t_idle();
        t_run();
        give_verdict();
    end

    // watchdog: the whole run needs a few hundred cycles at most
    initial begin
        #(50 * 5000);
        n_mismatch++;
        give_verdict();
    end
endmodule : test_pwm_timer_clock_prescale
